// ==== psbc_defs.svh ====
// Register offsets, field positions, reset values and timing figures of the
// power state and backup control block. Definitions only.
`ifndef PSBC_DEFS_SVH
`define PSBC_DEFS_SVH

`define PSBC_OFS_CHG_CTL 8'h1A
`define PSBC_OFS_BKP_CTL 8'h6B
`define PSBC_OFS_INT_STS 8'h00
`define PSBC_OFS_INT_MASK 8'h01
`define PSBC_OFS_INT_SENSE 8'h02
`define PSBC_OFS_PWR_CTL 8'h03
`define PSBC_OFS_PWR_STAT 8'h04

`define PSBC_CHG_EN_BIT 3
`define PSBC_CHG_VSEL_MSB 2
`define PSBC_BKP_LVL_MSB 2
`define PSBC_PWR_SLEEP_BIT 0
`define PSBC_SENSE_PROT_BIT 4

`define PSBC_RST_CHG_CTL 8'h00
`define PSBC_RST_BKP_CTL 8'h00
`define PSBC_RST_INT_MASK 4'hF
`define PSBC_RST_PWR_CTL 1'b0

`define PSBC_BKP_LVL_3V0 3'h6

`define PSBC_CLK_HZ 25000000
`define PSBC_THERM_DEB_US 8000
`define PSBC_THERM_DEB_CYC ((`PSBC_CLK_HZ / 1000) * `PSBC_THERM_DEB_US / 1000)

`endif

// ==== psbc_pkg.sv ====
// Types shared by the power state and backup control block.
// Assumes nothing of its surroundings.
package psbc_pkg;

  typedef enum logic [2:0] {
    PSBC_OFF,
    PSBC_ON,
    PSBC_SLEEP,
    PSBC_STBY,
    PSBC_COIN
  } psbc_state_t;

  typedef logic [7:0] psbc_byte_t;

endpackage : psbc_pkg

// ==== psbc_sync.sv ====
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes the inputs are levels that stay stable for several clock periods.
`timescale 1ns/10ps
`default_nettype none

module psbc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Levels.
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : psbc_sync

`default_nettype wire

// ==== psbc_debounce.sv ====
// Persistence filter: the output rises once the input has stayed high for
// LIMIT consecutive cycles and falls with the input.
// Assumes a synchronised input.
`timescale 1ns/10ps
`default_nettype none

module psbc_debounce #(
  parameter int LIMIT = 200000
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Filtered level.
  input wire logic level,
  output logic held
);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic done;

  assign done = (cnt_r >= 32'(LIMIT - 1));
  // Any drop before the limit restarts the count.
  assign cnt_nxt = !level ? 32'h0 : (done ? cnt_r : cnt_r + 32'h1); // RL23

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 32'h0;
      held <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      held <= level && done; // RL13
    end
  end

endmodule : psbc_debounce

`default_nettype wire

// ==== psbc_top.sv ====
// Power state machine, backup domain supply switching, backup cell charger
// control and die temperature supervision.
// Assumes comparator levels arrive asynchronously and register writes come
// from logic on MCLK.
// Notes on behaviour
// RL1 - Backup supply stays on; main input preferred.
// RL2 - Start at 1.0 V until main input appears.
// RL3 - Input removed: regulator gives way to cell switch.
// RL4 - Code 110: regulate above high, cell below low.
// RL5 - Level field: only code 110 is valid.
// RL6 - Below low threshold use cell; no cell, off.
// RL7 - Charger register: enable bit 3, voltage 2:0.
// RL8 - Voltage codes map 2.50 V up to 3.30 V.
// RL9 - High charge current in ON, low elsewhere.
// RL10 - No charging in OFF or under undervoltage.
// RL11 - Each warning threshold crossing raises its interrupt.
// RL12 - Current temperature sense bits are readable.
// RL13 - Shutdown only after 8.0 ms continuous overtemperature.
// RL14 - Exactly five power states.
// RL15 - ON needs input above undervoltage and enable.
// RL16 - Reset output released in ON.
// RL17 - ON goes to Coin Cell on undervoltage.
// RL18 - OFF drives reset low; leaves on turn-on.
// RL19 - Enable low or thermal trip enters OFF; enable low enters Sleep when selected.
// RL20 - Interrupt output only in Sleep, Standby, ON.
// RL21 - Thermal protection holds OFF until cooled.
// RL22 - Coin Cell ignores turn-on, goes OFF on input.
// RL23 - Debounce restarts when overtemperature drops early.
// RL24 - Warnings latch until cleared; output gated by state.
`timescale 1ns/10ps
`default_nettype none
`include "psbc_defs.svh"

module psbc_top #(
  parameter int THERM_DEB_CYC = `PSBC_THERM_DEB_CYC
) (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RST_N,
  // Comparators and pins, asynchronous.
  input wire logic VIN_ABOVE_UNDERVOLTAGE_DETECT,
  input wire logic VIN_ABOVE_INPUT_HIGH_THRESHOLD,
  input wire logic VIN_BELOW_INPUT_LOW_THRESHOLD,
  input wire logic CELL_PRESENT,
  input wire logic EN,
  input wire logic STBY,
  input wire logic [3:0] TEMP_WARN,
  input wire logic TEMP_SHDN,
  // Register port.
  input wire logic [7:0] REG_ADDR,
  input wire psbc_pkg::psbc_byte_t REG_WDATA,
  input wire logic REG_WE,
  output psbc_pkg::psbc_byte_t REG_RDATA,
  // Backup domain supply.
  output logic BKP_SRC_CELL,
  output logic BKP_INIT_LEVEL,
  output logic BKP_REG_3V0,
  output logic BKP_SUPPLY_ON,
  // Charger.
  output logic CHG_ON,
  output logic CHG_HIGH_CURRENT,
  output logic [2:0] CHG_VSEL,
  // Open-drain reset and interrupt, driven low while enabled.
  output logic POR_OUT_O,
  output logic POR_OUT_OE,
  output logic INT_OUT_O,
  output logic INT_OUT_OE,
  // Power state.
  output psbc_pkg::psbc_state_t PWR_STATE
);

  import psbc_pkg::*;

  logic [9:0] sync_d;
  logic [9:0] sync_q;
  logic uv_ok;
  logic vin_hi;
  logic vin_lo;
  logic cell_ok;
  logic en_s;
  logic stby_s;
  logic [3:0] temp_s;
  logic shdn_s;
  logic trip;

  assign sync_d = {TEMP_SHDN, TEMP_WARN, STBY, EN, CELL_PRESENT, VIN_BELOW_INPUT_LOW_THRESHOLD, VIN_ABOVE_INPUT_HIGH_THRESHOLD};

  psbc_sync #(.WIDTH(10)) u_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .d(sync_d),
    .q(sync_q)
  );

  psbc_sync #(.WIDTH(1)) u_sync_uv (
    .clk(MCLK),
    .rst_n(RST_N),
    .d(VIN_ABOVE_UNDERVOLTAGE_DETECT),
    .q(uv_ok)
  );

  assign vin_hi = sync_q[0];
  assign vin_lo = sync_q[1];
  assign cell_ok = sync_q[2];
  assign en_s = sync_q[3];
  assign stby_s = sync_q[4];
  assign temp_s = sync_q[8:5];
  assign shdn_s = sync_q[9];

  psbc_debounce #(.LIMIT(THERM_DEB_CYC)) u_deb (
    .clk(MCLK),
    .rst_n(RST_N),
    .level(shdn_s),
    .held(trip)
  );

  // Registers.
  logic [3:0] chg_ctl_r;
  logic [2:0] bkp_lvl_r;
  logic [3:0] int_sts_r;
  logic [3:0] int_sts_nxt;
  logic [3:0] int_mask_r;
  logic sleep_sel_r;
  logic [3:0] temp_prev_r;
  logic [3:0] temp_edge;
  logic prot_r;
  logic prot_nxt;
  logic wr_chg;
  logic wr_bkp;
  logic wr_sts;
  logic wr_mask;
  logic wr_pwr;
  logic [3:0] sts_clr;

  assign wr_chg = REG_WE && (REG_ADDR == `PSBC_OFS_CHG_CTL);
  assign wr_bkp = REG_WE && (REG_ADDR == `PSBC_OFS_BKP_CTL);
  assign wr_sts = REG_WE && (REG_ADDR == `PSBC_OFS_INT_STS);
  assign wr_mask = REG_WE && (REG_ADDR == `PSBC_OFS_INT_MASK);
  assign wr_pwr = REG_WE && (REG_ADDR == `PSBC_OFS_PWR_CTL);

  // Either crossing direction of a warning threshold is an event.
  assign temp_edge = temp_s ^ temp_prev_r; // RL11
  assign sts_clr = wr_sts ? REG_WDATA[3:0] : 4'h0;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sts
      // A crossing in the clearing cycle keeps its flag.
      assign int_sts_nxt[gi] = temp_edge[gi] | (int_sts_r[gi] & ~sts_clr[gi]); // RL24
    end
  endgenerate

  // Protection latches on the debounced trip and holds until cooled.
  assign prot_nxt = trip | (prot_r & shdn_s); // RL21

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      chg_ctl_r <= 4'(`PSBC_RST_CHG_CTL);
      bkp_lvl_r <= 3'(`PSBC_RST_BKP_CTL);
      int_mask_r <= `PSBC_RST_INT_MASK;
      sleep_sel_r <= `PSBC_RST_PWR_CTL;
      int_sts_r <= 4'h0;
      temp_prev_r <= 4'h0;
      prot_r <= 1'b0;
    end else begin
      if (wr_chg) chg_ctl_r <= REG_WDATA[`PSBC_CHG_EN_BIT:0]; // RL7
      if (wr_bkp) bkp_lvl_r <= REG_WDATA[`PSBC_BKP_LVL_MSB:0];
      if (wr_mask) int_mask_r <= REG_WDATA[3:0];
      if (wr_pwr) sleep_sel_r <= REG_WDATA[`PSBC_PWR_SLEEP_BIT];
      int_sts_r <= int_sts_nxt;
      temp_prev_r <= temp_s;
      prot_r <= prot_nxt;
    end
  end

  // Power state machine.
  psbc_state_t state_r;
  psbc_state_t state_nxt;
  logic turn_on;
  logic en_off_tgt_sleep;

  assign turn_on = uv_ok && en_s && !prot_r; // RL15 RL21
  assign en_off_tgt_sleep = sleep_sel_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r) // RL14
      PSBC_COIN: begin
        if (uv_ok) state_nxt = PSBC_OFF; // RL22
      end
      PSBC_OFF: begin
        if (!uv_ok) state_nxt = PSBC_COIN;
        else if (turn_on) state_nxt = PSBC_ON; // RL18
      end
      PSBC_ON: begin
        if (!uv_ok) state_nxt = PSBC_COIN; // RL17
        else if (trip || prot_r) state_nxt = PSBC_OFF; // RL19
        else if (!en_s) state_nxt = en_off_tgt_sleep ? PSBC_SLEEP : PSBC_OFF; // RL19
        else if (stby_s) state_nxt = PSBC_STBY;
      end
      PSBC_STBY: begin
        if (!uv_ok) state_nxt = PSBC_COIN;
        else if (trip || prot_r) state_nxt = PSBC_OFF; // RL19
        else if (!en_s) state_nxt = en_off_tgt_sleep ? PSBC_SLEEP : PSBC_OFF;
        else if (!stby_s) state_nxt = PSBC_ON;
      end
      PSBC_SLEEP: begin
        if (!uv_ok) state_nxt = PSBC_COIN;
        else if (trip || prot_r) state_nxt = PSBC_OFF;
        else if (en_s) state_nxt = PSBC_ON;
      end
      default: state_nxt = PSBC_COIN;
    endcase
  end

  // Backup domain supply source and level.
  logic src_cell_r;
  logic src_cell_nxt;
  logic init_lvl_r;
  logic lvl_valid;

  // Main input wins above the high threshold; between thresholds the source holds.
  assign src_cell_nxt = vin_hi ? 1'b0 : (vin_lo ? 1'b1 : src_cell_r); // RL1 RL3 RL4 RL6
  assign lvl_valid = (bkp_lvl_r == `PSBC_BKP_LVL_3V0); // RL5

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= PSBC_COIN;
      src_cell_r <= 1'b1;
      init_lvl_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      src_cell_r <= src_cell_nxt;
      if (vin_hi) init_lvl_r <= 1'b0; // RL2
    end
  end

  // Charger qualification.
  logic chg_state_ok;
  logic chg_on;
  logic chg_hi;

  assign chg_state_ok = (state_r == PSBC_ON) || (state_r == PSBC_SLEEP) || (state_r == PSBC_STBY);
  assign chg_on = chg_ctl_r[`PSBC_CHG_EN_BIT] && chg_state_ok && uv_ok; // RL10
  assign chg_hi = chg_on && (state_r == PSBC_ON); // RL9

  // Interrupt output.
  logic int_state_ok;
  logic int_req;

  assign int_state_ok = chg_state_ok; // RL20
  assign int_req = |(int_sts_r & ~int_mask_r) && int_state_ok; // RL24

  // Read data.
  psbc_byte_t rdata;

  always_comb begin
    rdata = 8'h00;
    unique case (REG_ADDR)
      `PSBC_OFS_CHG_CTL: rdata = {4'h0, chg_ctl_r};
      `PSBC_OFS_BKP_CTL: rdata = {5'h00, bkp_lvl_r};
      `PSBC_OFS_INT_STS: rdata = {4'h0, int_sts_r};
      `PSBC_OFS_INT_MASK: rdata = {4'h0, int_mask_r};
      `PSBC_OFS_INT_SENSE: rdata = {3'h0, prot_r, temp_s}; // RL12
      `PSBC_OFS_PWR_CTL: rdata = {7'h00, sleep_sel_r};
      `PSBC_OFS_PWR_STAT: rdata = {5'h00, state_r};
      default: rdata = 8'h00;
    endcase
  end

  // Registered outputs.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
      BKP_SRC_CELL <= 1'b1;
      BKP_INIT_LEVEL <= 1'b1;
      BKP_REG_3V0 <= 1'b0;
      BKP_SUPPLY_ON <= 1'b1;
      CHG_ON <= 1'b0;
      CHG_HIGH_CURRENT <= 1'b0;
      CHG_VSEL <= 3'h0;
      POR_OUT_O <= 1'b0;
      POR_OUT_OE <= 1'b1;
      INT_OUT_O <= 1'b0;
      INT_OUT_OE <= 1'b0;
      PWR_STATE <= PSBC_COIN;
    end else begin
      REG_RDATA <= rdata;
      BKP_SRC_CELL <= src_cell_r;
      BKP_INIT_LEVEL <= init_lvl_r; // RL2
      BKP_REG_3V0 <= !src_cell_r && !init_lvl_r && lvl_valid; // RL4
      BKP_SUPPLY_ON <= !(src_cell_r && !cell_ok); // RL1 RL6
      CHG_ON <= chg_on;
      CHG_HIGH_CURRENT <= chg_hi;
      CHG_VSEL <= chg_ctl_r[`PSBC_CHG_VSEL_MSB:0]; // RL8
      POR_OUT_O <= 1'b0;
      POR_OUT_OE <= (state_r != PSBC_ON); // RL16 RL18 RL22
      INT_OUT_O <= 1'b0;
      INT_OUT_OE <= int_req; // RL20
      PWR_STATE <= state_r;
    end
  end

endmodule : psbc_top

`default_nettype wire

// ==== psbc_props.sv ====
// Port assertions of the power state and backup control block.
// Assumes it is bound to psbc_top with the same debounce count.
`timescale 1ns/10ps
`default_nettype none
`include "psbc_defs.svh"
module psbc_props #(
  parameter int THERM_DEB_CYC = 8
) (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RST_N,
  // Inputs.
  input wire logic EN,
  input wire logic TEMP_SHDN,
  input wire logic [7:0] REG_ADDR,
  input wire psbc_pkg::psbc_byte_t REG_WDATA,
  input wire logic REG_WE,
  // Outputs.
  input wire psbc_pkg::psbc_byte_t REG_RDATA,
  input wire logic BKP_SRC_CELL,
  input wire logic BKP_INIT_LEVEL,
  input wire logic BKP_REG_3V0,
  input wire logic BKP_SUPPLY_ON,
  input wire logic CHG_ON,
  input wire logic CHG_HIGH_CURRENT,
  input wire logic [2:0] CHG_VSEL,
  input wire logic POR_OUT_OE,
  input wire logic INT_OUT_OE,
  input wire psbc_pkg::psbc_state_t PWR_STATE
);
  import psbc_pkg::*;
  logic [9:0] shdn_run_r;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  // Counts consecutive cycles with the shutdown comparator high.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) shdn_run_r <= 10'h000;
    else if (!TEMP_SHDN) shdn_run_r <= 10'h000;
    else if (shdn_run_r != 10'h3FF) shdn_run_r <= shdn_run_r + 10'h001;
  end
  a_por_in_on: assert property (POR_OUT_OE == (PWR_STATE != PSBC_ON))
    else $error("reset output does not follow the on state");
  a_int_gated: assert property (INT_OUT_OE |-> PWR_STATE inside {PSBC_ON, PSBC_SLEEP, PSBC_STBY})
    else $error("interrupt asserted in an inactive state");
  a_chg_state: assert property (CHG_ON |-> PWR_STATE inside {PSBC_ON, PSBC_SLEEP, PSBC_STBY})
    else $error("charger on in off or coin state");
  a_high_cur: assert property (CHG_HIGH_CURRENT == (CHG_ON && PWR_STATE == PSBC_ON))
    else $error("charge current level wrong for state");
  a_coin_exit: assert property (PWR_STATE == PSBC_COIN |=> PWR_STATE inside {PSBC_COIN, PSBC_OFF})
    else $error("coin state left to a state other than off");
  a_on_entry: assert property (PWR_STATE == PSBC_OFF ##1 PWR_STATE == PSBC_ON |-> $past(EN, 3))
    else $error("on entered without enable");
  a_therm_wait: assert property ((PWR_STATE == PSBC_ON ##1 PWR_STATE == PSBC_OFF && $past(EN, 3) && $past(EN, 5))
    |-> shdn_run_r >= THERM_DEB_CYC)
    else $error("thermal shutdown before the debounce time");
  a_bkp_on: assert property (!BKP_SUPPLY_ON |-> BKP_SRC_CELL)
    else $error("backup supply off while on main input");
  a_reg_level: assert property (BKP_REG_3V0 |-> !BKP_SRC_CELL && !BKP_INIT_LEVEL)
    else $error("regulator level without main source");
  a_vsel_write: assert property (REG_WE && REG_ADDR == `PSBC_OFS_CHG_CTL |-> ##2 CHG_VSEL == 3'($past(REG_WDATA, 2)))
    else $error("charger voltage code not taken from write");
  a_unused_zero: assert property (REG_ADDR == `PSBC_OFS_CHG_CTL |=> REG_RDATA[7:4] == 4'h0)
    else $error("unused charger bits read nonzero");
endmodule : psbc_props
bind psbc_top psbc_props #(.THERM_DEB_CYC(THERM_DEB_CYC)) u_props (.MCLK, .RST_N, .EN, .TEMP_SHDN, .REG_ADDR,
  .REG_WDATA, .REG_WE, .REG_RDATA, .BKP_SRC_CELL, .BKP_INIT_LEVEL, .BKP_REG_3V0, .BKP_SUPPLY_ON, .CHG_ON,
  .CHG_HIGH_CURRENT, .CHG_VSEL, .POR_OUT_OE, .INT_OUT_OE, .PWR_STATE);
`default_nettype wire

// ==== psbc_host.sv ====
// Register master standing in for the system processor.
// Assumes the block samples the register port on the rising MCLK edge.
`timescale 1ns/10ps
`default_nettype none
module psbc_host (
  // Clock.
  input wire logic MCLK,
  // Register port.
  output logic [7:0] REG_ADDR,
  output psbc_pkg::psbc_byte_t REG_WDATA,
  output logic REG_WE,
  input wire psbc_pkg::psbc_byte_t REG_RDATA
);
  import psbc_pkg::*;
  initial begin
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    REG_WE = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WE <= 1'b1;
    @(posedge MCLK);
    REG_WE <= 1'b0;
  endtask : wr
  // Read data is registered, so it is taken two edges after the address.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge MCLK);
    REG_ADDR <= a;
    repeat (2) @(posedge MCLK);
    #1 d = REG_RDATA;
  endtask : rd
endmodule : psbc_host
`default_nettype wire

// ==== psbc_tb_top.sv ====
// Self-checking testbench of the power state and backup control block.
// Assumes a short thermal debounce count to keep the run brief.
`timescale 1ns/10ps
`default_nettype none
module psbc_tb_top;
  import psbc_pkg::*;
  localparam int DEB = 8;
  logic MCLK = 1'b0, RST_N = 1'b0, EN = 1'b0, STBY = 1'b0, TEMP_SHDN = 1'b0, CELL_PRESENT = 1'b1;
  logic VIN_ABOVE_UNDERVOLTAGE_DETECT = 1'b0, VIN_ABOVE_INPUT_HIGH_THRESHOLD = 1'b0, VIN_BELOW_INPUT_LOW_THRESHOLD = 1'b1;
  logic [3:0] TEMP_WARN = 4'h0;
  logic [7:0] REG_ADDR, rv;
  psbc_byte_t REG_WDATA, REG_RDATA;
  logic REG_WE, BKP_SRC_CELL, BKP_INIT_LEVEL, BKP_REG_3V0, BKP_SUPPLY_ON, CHG_ON, CHG_HIGH_CURRENT;
  logic POR_OUT_O, POR_OUT_OE, INT_OUT_O, INT_OUT_OE;
  logic [2:0] CHG_VSEL;
  psbc_state_t PWR_STATE;
  int bad_count = 0;
  int num_checks = 0;
  always #20 MCLK = ~MCLK;
  psbc_host u_host (.MCLK, .REG_ADDR, .REG_WDATA, .REG_WE, .REG_RDATA);
  psbc_top #(.THERM_DEB_CYC(DEB)) u_dut (.MCLK, .RST_N, .VIN_ABOVE_UNDERVOLTAGE_DETECT, .VIN_ABOVE_INPUT_HIGH_THRESHOLD, .VIN_BELOW_INPUT_LOW_THRESHOLD,
    .CELL_PRESENT, .EN, .STBY, .TEMP_WARN, .TEMP_SHDN, .REG_ADDR, .REG_WDATA, .REG_WE, .REG_RDATA,
    .BKP_SRC_CELL, .BKP_INIT_LEVEL, .BKP_REG_3V0, .BKP_SUPPLY_ON, .CHG_ON, .CHG_HIGH_CURRENT, .CHG_VSEL,
    .POR_OUT_O, .POR_OUT_OE, .INT_OUT_O, .INT_OUT_OE, .PWR_STATE);
  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    num_checks++;
    if (act !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : cyc
  task automatic wait_st(input psbc_state_t s);
    for (int i = 0; i < 40 && PWR_STATE !== s; i++) cyc(1);
    chk(PWR_STATE, s);
  endtask : wait_st
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic t_reset();
    chk(PWR_STATE, PSBC_COIN);
    chk(BKP_INIT_LEVEL, 1'b1);
    u_host.rd(8'h1A, rv);
    chk(rv, 8'h00);
    u_host.rd(8'h6B, rv);
    chk(rv, 8'h00);
    u_host.rd(8'h55, rv);
    chk(rv, 8'h00);
  endtask : t_reset
  task automatic t_power_up();
    @(posedge MCLK);
    VIN_ABOVE_UNDERVOLTAGE_DETECT <= 1'b1;
    EN <= 1'b1;
    VIN_ABOVE_INPUT_HIGH_THRESHOLD <= 1'b1;
    VIN_BELOW_INPUT_LOW_THRESHOLD <= 1'b0;
    wait_st(PSBC_ON);
    chk(POR_OUT_OE, 1'b0);
    chk(BKP_SRC_CELL, 1'b0);
    chk(BKP_INIT_LEVEL, 1'b0);
  endtask : t_power_up
  task automatic t_regs();
    u_host.wr(8'h6B, 8'h05);
    cyc(3);
    chk(BKP_REG_3V0, 1'b0);
    u_host.wr(8'h6B, 8'hFE);
    u_host.rd(8'h6B, rv);
    chk(rv, 8'h06);
    chk(BKP_REG_3V0, 1'b1);
    for (int c = 0; c < 8; c++) begin
      u_host.wr(8'h1A, 8'(8 + c));
      cyc(2);
      chk(CHG_VSEL, 8'(c));
    end
    chk(CHG_HIGH_CURRENT, 1'b1);
    u_host.wr(8'h1A, 8'hFF);
    u_host.rd(8'h1A, rv);
    chk(rv, 8'h0F);
  endtask : t_regs
  task automatic t_stby();
    @(posedge MCLK);
    STBY <= 1'b1;
    wait_st(PSBC_STBY);
    chk({CHG_ON, CHG_HIGH_CURRENT}, 8'h02);
    @(posedge MCLK);
    STBY <= 1'b0;
    wait_st(PSBC_ON);
  endtask : t_stby
  task automatic t_warn();
    u_host.wr(8'h01, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge MCLK);
      TEMP_WARN[i] <= 1'b1;
      cyc(6);
      u_host.rd(8'h02, rv);
      chk(rv, 8'(1 << i));
      u_host.rd(8'h00, rv);
      chk(rv, 8'(1 << i));
      chk(INT_OUT_OE, 1'b1);
      u_host.wr(8'h00, 8'(1 << i));
      cyc(3);
      chk(INT_OUT_OE, 1'b0);
      @(posedge MCLK);
      TEMP_WARN[i] <= 1'b0;
      cyc(6);
      u_host.rd(8'h00, rv);
      chk(rv, 8'(1 << i));
      u_host.wr(8'h00, 8'h0F);
    end
  endtask : t_warn
  // Enable low with sleep selected; leaves warning flag 0 pending on return to ON.
  task automatic t_sleep();
    u_host.wr(8'h03, 8'h01);
    u_host.rd(8'h03, rv);
    chk(rv, 8'h01);
    @(posedge MCLK);
    EN <= 1'b0;
    wait_st(PSBC_SLEEP);
    chk({CHG_ON, CHG_HIGH_CURRENT}, 8'h02);
    u_host.rd(8'h04, rv);
    chk(rv, 8'(PSBC_SLEEP));
    @(posedge MCLK);
    TEMP_WARN[0] <= 1'b1;
    cyc(6);
    chk(INT_OUT_OE, 1'b1);
    u_host.wr(8'h01, 8'h01);
    cyc(3);
    chk(INT_OUT_OE, 1'b0);
    u_host.wr(8'h01, 8'h00);
    @(posedge MCLK);
    TEMP_WARN[0] <= 1'b0;
    u_host.wr(8'h03, 8'h00);
    @(posedge MCLK);
    EN <= 1'b1;
    wait_st(PSBC_ON);
    chk(INT_OUT_OE, 1'b1);
  endtask : t_sleep
  task automatic t_thermal();
    @(posedge MCLK);
    TEMP_SHDN <= 1'b1;
    cyc(DEB / 2);
    @(posedge MCLK);
    TEMP_SHDN <= 1'b0;
    cyc(20);
    chk(PWR_STATE, PSBC_ON);
    @(posedge MCLK);
    TEMP_SHDN <= 1'b1;
    wait_st(PSBC_OFF);
    chk({POR_OUT_OE, CHG_ON}, 8'h02);
    chk(INT_OUT_OE, 1'b0);
    chk({POR_OUT_O, INT_OUT_O}, 8'h00);
    u_host.rd(8'h02, rv);
    chk(rv, 8'h10);
    cyc(20);
    chk(PWR_STATE, PSBC_OFF);
    @(posedge MCLK);
    TEMP_SHDN <= 1'b0;
    wait_st(PSBC_ON);
    chk(INT_OUT_OE, 1'b1);
  endtask : t_thermal
  task automatic t_en_coin();
    @(posedge MCLK);
    EN <= 1'b0;
    wait_st(PSBC_OFF);
    chk(CHG_ON, 1'b0);
    @(posedge MCLK);
    EN <= 1'b1;
    wait_st(PSBC_ON);
    @(posedge MCLK);
    VIN_ABOVE_UNDERVOLTAGE_DETECT <= 1'b0;
    VIN_ABOVE_INPUT_HIGH_THRESHOLD <= 1'b0;
    VIN_BELOW_INPUT_LOW_THRESHOLD <= 1'b1;
    wait_st(PSBC_COIN);
    cyc(3);
    chk({POR_OUT_OE, BKP_SRC_CELL, CHG_ON}, 8'h06);
    chk(INT_OUT_OE, 1'b0);
    @(posedge MCLK);
    EN <= 1'b0;
    cyc(4);
    @(posedge MCLK);
    EN <= 1'b1;
    CELL_PRESENT <= 1'b0;
    cyc(20);
    chk(PWR_STATE, PSBC_COIN);
    chk(BKP_SUPPLY_ON, 1'b0);
  endtask : t_en_coin
  initial begin
    repeat (5) @(posedge MCLK);
    RST_N <= 1'b1;
    cyc(1);
    t_reset();
    t_power_up();
    t_regs();
    t_stby();
    t_warn();
    t_sleep();
    t_thermal();
    t_en_coin();
    close_out();
  end
  initial begin
    #(40 * 5000);
    bad_count++;
    close_out();
  end
endmodule : psbc_tb_top
`default_nettype wire
